/* design/hotplug_slot_signal_config.sv */
// Hot-plug slot signal configuration and per-port slot sequencing.
// Assumes slot pins synchronous to clk_i and a classic Wishbone master;
// rst_i is the fundamental reset, hot_rst_i an ordinary reset.
`timescale 1ns/1ps
`include "hotplug_map.svh"

module hotplug_slot_signal_config
  import hotplug_pkg::*;
#(
  parameter int NPORTS      = 2,
  parameter int ADDR_W      = 12,
  parameter int STEP_CYCLES = `STEP_CYCLES
) (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              hot_rst_i,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [ADDR_W-1:0] wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  input  wire logic [NPORTS-1:0] latch_sensor_in_i,
  input  wire logic [NPORTS-1:0] presence_detect_in_i,
  input  wire logic [NPORTS-1:0] slot_power_good_in_i,
  input  wire logic [NPORTS-1:0] receiver_detect_i,
  output logic      [NPORTS-1:0] attention_indicator_out_o,
  output logic      [NPORTS-1:0] power_indicator_out_o,
  output logic      [NPORTS-1:0] slot_power_enable_out_o,
  output logic      [NPORTS-1:0] interlock_out_o,
  output logic      [NPORTS-1:0] slot_reset_out_o,
  output logic      [NPORTS-1:0] presence_report_o
);

  localparam logic [7:0]  PORT_MASK = 8'((1 << NPORTS) - 1);
  localparam logic [31:0] CTL_MASK  = {8'h00, PORT_MASK, PORT_MASK,
                                       PORT_MASK};
  localparam logic [31:0] CAP_MASK  = {24'h00_0000, PORT_MASK};

  function automatic logic [31:0] merge_lanes(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  sel);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return res;
  endfunction : merge_lanes

  function automatic logic addr_hit(input logic [ADDR_W-1:0] adr,
                                    input logic [11:0]       off);
    logic [ADDR_W-1:0] off_w;
    off_w = ADDR_W'(off);
    return adr[ADDR_W-1:2] == off_w[ADDR_W-1:2];
  endfunction : addr_hit

  logic [31:0]       config_reg;
  logic [31:0]       slot_control;
  logic [31:0]       slot_cap;
  logic [31:0]       slot_status;
  logic [NPORTS-1:0] ilock_write;
  logic [31:0]       next_rdata;
  logic              bus_req;
  logic              wr_take;
  logic              port_rst;

  assign bus_req  = wb_cyc_i & wb_stb_i;
  // Writes land on the edge where the master sees ack
  assign wr_take  = bus_req & wb_we_i & wb_ack_o;
  assign port_rst = rst_i | hot_rst_i;

  presence_select_type pres_sel;
  reset_mode_type      rst_mode;

  assign pres_sel = presence_select_type'(config_reg[`CFG_PRES_SEL_LSB +: 2]);
  assign rst_mode = reset_mode_type'(config_reg[`CFG_RST_MODE_LSB +: 2]);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_req & ~wb_ack_o;
    end
  end

  always_comb begin
    next_rdata = 32'h0000_0000;
    if (addr_hit(wb_adr_i, `OFF_CONFIG)) begin
      next_rdata = config_reg;
    end else if (addr_hit(wb_adr_i, `OFF_SLOT_CONTROL)) begin
      next_rdata = slot_control;
    end else if (addr_hit(wb_adr_i, `OFF_SLOT_CAP)) begin
      next_rdata = slot_cap;
    end else if (addr_hit(wb_adr_i, `OFF_SLOT_STATUS)) begin
      next_rdata = slot_status;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (bus_req & ~wb_ack_o) begin
      wb_dat_o <= next_rdata;
    end
  end

  // Only the fundamental reset restores the configuration
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      config_reg <= `CFG_RESET;
    end else if (wr_take & addr_hit(wb_adr_i, `OFF_CONFIG)) begin
      config_reg <= merge_lanes(config_reg, wb_dat_i, wb_sel_i);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      slot_cap <= 32'h0000_0000;
    end else if (wr_take & addr_hit(wb_adr_i, `OFF_SLOT_CAP)) begin
      slot_cap <= merge_lanes(slot_cap, wb_dat_i, wb_sel_i) & CAP_MASK;
    end
  end

  always_ff @(posedge clk_i) begin
    if (port_rst) begin
      slot_control <= 32'h0000_0000;
    end else if (wr_take & addr_hit(wb_adr_i, `OFF_SLOT_CONTROL)) begin
      slot_control <= merge_lanes(slot_control, wb_dat_i, wb_sel_i)
                      & CTL_MASK;
    end
  end

  // Interlock bits are write-one actions and are never stored
  always_ff @(posedge clk_i) begin
    if (port_rst) begin
      ilock_write <= '0;
    end else if (wr_take & addr_hit(wb_adr_i, `OFF_SLOT_CONTROL)
                 & wb_sel_i[`CTL_ILOCK_LANE]) begin
      ilock_write <= wb_dat_i[`CTL_ILOCK_LSB +: NPORTS];
    end else begin
      ilock_write <= '0;
    end
  end

  genvar p;
  generate
    for (p = 0; p < 4; p++) begin : g_unused_status
      if (p >= NPORTS) begin : g_zero
        assign slot_status[p*`STS_STRIDE +: `STS_STRIDE] = 8'h00;
      end
    end

    for (p = 0; p < NPORTS; p++) begin : g_port
      slot_state_type state;
      logic           latch_sense;
      logic           latch_open;
      logic           lock_state;
      logic           good_sense;
      logic           pres_sense;
      logic           auto_off;
      logic           want_power;
      logic           stable;
      logic           up_start;
      logic           down_start;
      logic           seq_done;
      logic           ilock_start;
      logic           ilock_done;
      logic           power_en;
      logic           reset_on;
      logic           ilock_level;
      logic           attn_q;
      logic           pind_q;
      logic           pwr_q;
      logic           ilock_q;
      logic           pres_q;

      assign latch_sense = latch_sensor_in_i[p]
                           ^ config_reg[`CFG_INV_LATCH];
      assign latch_open  = latch_sense
                           & ~config_reg[`CFG_LATCH_LOCK];
      assign lock_state  = latch_sense
                           & config_reg[`CFG_LATCH_LOCK];
      assign good_sense  = slot_power_good_in_i[p]
                           ^ config_reg[`CFG_INV_PWR_GOOD];
      assign pres_sense  = presence_detect_in_i[p]
                           ^ config_reg[`CFG_INV_PRESENCE];
      assign auto_off    = config_reg[`CFG_AUTO_OFF] & slot_cap[p]
                           & latch_open;
      assign want_power  = slot_control[`CTL_POWER_LSB + p]
                           & ~auto_off;
      // Reserved reset modes fall back to power-enable control
      assign stable      = (rst_mode == RST_BY_POWER_GOOD) ? good_sense
                                                           : 1'b1;
      assign up_start    = (state == SLOT_WAIT_GOOD) & want_power & stable;
      assign down_start  = (state == SLOT_ON) & ~want_power;
      assign ilock_start = ilock_write[p]
                           & ~config_reg[`CFG_ILOCK_TOGGLE];

      step_timer #(
        .STEP_CYCLES (STEP_CYCLES),
        .COUNT_W     (8)
      ) u_seq_timer (
        .clk_i   (clk_i),
        .rst_i   (port_rst),
        .start_i (up_start | down_start),
        .count_i (up_start ? config_reg[`CFG_P2R_LSB +: 8]
                           : config_reg[`CFG_R2P_LSB +: 8]),
        .busy_o  (),
        .done_o  (seq_done)
      );

      step_timer #(
        .STEP_CYCLES (STEP_CYCLES),
        .COUNT_W     (8)
      ) u_ilock_timer (
        .clk_i   (clk_i),
        .rst_i   (port_rst),
        .start_i (ilock_start),
        .count_i (`ILOCK_STEPS),
        .busy_o  (),
        .done_o  (ilock_done)
      );

      // Reset is asserted before power is removed, or on the same edge when port_rst forces both
      always_ff @(posedge clk_i) begin
        if (port_rst) begin
          state    <= SLOT_OFF;
          power_en <= 1'b0;
          reset_on <= 1'b1;
        end else begin
          unique case (state)
            SLOT_OFF: begin
              if (want_power) begin
                power_en <= 1'b1;
                state    <= SLOT_WAIT_GOOD;
              end
            end
            SLOT_WAIT_GOOD: begin
              if (!want_power) begin
                power_en <= 1'b0;
                state    <= SLOT_OFF;
              end else if (stable) begin
                state <= SLOT_UP_DELAY;
              end
            end
            SLOT_UP_DELAY: begin
              if (!want_power) begin
                power_en <= 1'b0;
                state    <= SLOT_OFF;
              end else if (seq_done) begin
                reset_on <= 1'b0;
                state    <= SLOT_ON;
              end
            end
            SLOT_ON: begin
              if (!want_power) begin
                reset_on <= 1'b1;
                state    <= SLOT_DOWN_DELAY;
              end else if (!stable) begin
                reset_on <= 1'b1;
                state    <= SLOT_WAIT_GOOD;
              end
            end
            SLOT_DOWN_DELAY: begin
              if (seq_done) begin
                power_en <= 1'b0;
                state    <= SLOT_OFF;
              end
            end
          endcase
        end
      end

      always_ff @(posedge clk_i) begin
        if (port_rst) begin
          ilock_level <= 1'b0;
        end else if (ilock_write[p] & config_reg[`CFG_ILOCK_TOGGLE]) begin
          ilock_level <= ~ilock_level;
        end else if (ilock_start) begin
          ilock_level <= 1'b1;
        end else if (ilock_done) begin
          ilock_level <= 1'b0;
        end
      end

      always_ff @(posedge clk_i) begin
        if (port_rst) begin
          attn_q  <= config_reg[`CFG_INV_ATTN];
          pind_q  <= config_reg[`CFG_INV_PIND];
          pwr_q   <= config_reg[`CFG_INV_PWR_EN];
          ilock_q <= config_reg[`CFG_INV_ILOCK];
        end else begin
          attn_q  <= slot_control[`CTL_ATTN_LSB + p]
                     ^ config_reg[`CFG_INV_ATTN];
          pind_q  <= slot_control[`CTL_PIND_LSB + p]
                     ^ config_reg[`CFG_INV_PIND];
          pwr_q   <= power_en ^ config_reg[`CFG_INV_PWR_EN];
          ilock_q <= ilock_level ^ config_reg[`CFG_INV_ILOCK];
        end
      end

      always_ff @(posedge clk_i) begin
        if (port_rst) begin
          pres_q <= 1'b0;
        end else begin
          unique case (pres_sel)
            PRES_BOTH:   pres_q <= receiver_detect_i[p] | pres_sense;
            PRES_SIGNAL: pres_q <= pres_sense;
            PRES_ALWAYS: pres_q <= 1'b1;
            PRES_NEVER:  pres_q <= 1'b0;
          endcase
        end
      end

      assign attention_indicator_out_o[p] = attn_q;
      assign power_indicator_out_o[p]     = pind_q;
      assign slot_power_enable_out_o[p]   = pwr_q;
      assign interlock_out_o[p]           = ilock_q;
      assign slot_reset_out_o[p]          = reset_on;
      assign presence_report_o[p]         = pres_q;

      assign slot_status[p*`STS_STRIDE +: `STS_STRIDE] =
        {1'b0, ilock_level, reset_on, power_en,
         good_sense, lock_state, latch_open, pres_q};
    end
  endgenerate

endmodule : hotplug_slot_signal_config

/* design/hotplug_map.svh */
// Offsets, field positions, reset values and timing counts for the
// hot-plug slot signal configuration block.
// Included by the design files; holds definitions only.
`ifndef HOTPLUG_MAP_SVH
`define HOTPLUG_MAP_SVH

// Word offsets on the register bus (byte addresses)
`define OFF_CONFIG        12'h408
`define OFF_SLOT_CONTROL  12'h40C
`define OFF_SLOT_CAP      12'h410
`define OFF_SLOT_STATUS   12'h414

// Configuration register fields
`define CFG_INV_PRESENCE  1
`define CFG_INV_LATCH     3
`define CFG_INV_ATTN      4
`define CFG_INV_PIND      5
`define CFG_INV_PWR_EN    6
`define CFG_INV_ILOCK     7
`define CFG_INV_PWR_GOOD  8
`define CFG_PRES_SEL_LSB  9
`define CFG_AUTO_OFF      11
`define CFG_LATCH_LOCK    12
`define CFG_ILOCK_TOGGLE  13
`define CFG_RST_MODE_LSB  14
`define CFG_P2R_LSB       16
`define CFG_R2P_LSB       24
`define CFG_RESET         32'h1414_0800

// Slot control register: one byte lane per field, one bit per port
`define CTL_POWER_LSB     0
`define CTL_ATTN_LSB      8
`define CTL_PIND_LSB      16
`define CTL_ILOCK_LSB     24
`define CTL_ILOCK_LANE    3

// Slot status register: one byte per port
`define STS_STRIDE        8

// Timing
`define CLK_FREQ_KHZ      40000
`define STEP_TIME_MS      10
`define STEP_CYCLES       (`STEP_TIME_MS * `CLK_FREQ_KHZ)
`define ILOCK_PULSE_MS    100
`define ILOCK_STEPS       8'(`ILOCK_PULSE_MS / `STEP_TIME_MS)

`endif

/* design/hotplug_pkg.sv */
// Types shared by the hot-plug slot signal configuration block.
// Field encodings follow the configuration register layout.
package hotplug_pkg;

  typedef enum logic [1:0] {
    PRES_BOTH,
    PRES_SIGNAL,
    PRES_ALWAYS,
    PRES_NEVER
  } presence_select_type;

  typedef enum logic [1:0] {
    RST_BY_POWER_ENABLE,
    RST_BY_POWER_GOOD,
    RST_RESERVED_2,
    RST_RESERVED_3
  } reset_mode_type;

  typedef enum logic [2:0] {
    SLOT_OFF,
    SLOT_WAIT_GOOD,
    SLOT_UP_DELAY,
    SLOT_ON,
    SLOT_DOWN_DELAY
  } slot_state_type;

endpackage : hotplug_pkg

/* design/step_timer.sv */
// Restartable delay timer counting whole steps of STEP_CYCLES clocks.
// Assumes start_i is a one-cycle pulse; a new start restarts the count.
`timescale 1ns/1ps

module step_timer #(
  parameter int STEP_CYCLES = 400000,
  parameter int COUNT_W     = 8
) (
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  input  wire logic               start_i,
  input  wire logic [COUNT_W-1:0] count_i,
  output logic                    busy_o,
  output logic                    done_o
);

  localparam int PRE_W = $clog2(STEP_CYCLES + 1);
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(STEP_CYCLES - 1);

  logic [PRE_W-1:0]   prescale;
  logic [COUNT_W-1:0] remain;

  // The prescaler restarts with every start so a delay is never short
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_o   <= 1'b0;
      done_o   <= 1'b0;
      prescale <= '0;
      remain   <= '0;
    end else if (start_i) begin
      busy_o   <= (count_i != '0);
      done_o   <= (count_i == '0);
      prescale <= '0;
      remain   <= count_i;
    end else begin
      done_o <= 1'b0;
      if (busy_o) begin
        if (prescale == PRE_LAST) begin
          prescale <= '0;
          remain   <= remain - 1'b1;
          if (remain == COUNT_W'(1)) begin
            busy_o <= 1'b0;
            done_o <= 1'b1;
          end
        end else begin
          prescale <= prescale + 1'b1;
        end
      end
    end
  end

endmodule : step_timer

/* tb/hotplug_slot_signal_config_assertions.sv */
// Checker for the hot-plug slot block, bound to its top ports.
// Assumes aligned bus addresses; shadows config and indicator writes.
`timescale 1ns/1ps
`include "hotplug_map.svh"

module hotplug_slot_signal_config_assertions #(
  parameter int NPORTS = 2,
  parameter int ADDR_W = 12
) (
  input wire logic              clk_i,
  input wire logic              rst_i,
  input wire logic              hot_rst_i,
  input wire logic              wb_cyc_i,
  input wire logic              wb_stb_i,
  input wire logic              wb_we_i,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0]        wb_sel_i,
  input wire logic [31:0]       wb_dat_i,
  input wire logic [31:0]       wb_dat_o,
  input wire logic              wb_ack_o,
  input wire logic [NPORTS-1:0] presence_detect_in_i,
  input wire logic [NPORTS-1:0] receiver_detect_i,
  input wire logic [NPORTS-1:0] attention_indicator_out_o,
  input wire logic [NPORTS-1:0] power_indicator_out_o,
  input wire logic [NPORTS-1:0] slot_reset_out_o,
  input wire logic [NPORTS-1:0] presence_report_o
);
  logic [31:0]       cfg, cfg_d, ctl, ctl_d;
  logic              hot_q, wr, settled;
  logic [ADDR_W-1:0] adr;
  logic [1:0]        mode;
  logic [NPORTS-1:0] inv_pd;
  function automatic logic [31:0] merge(logic [31:0] o, logic [31:0] n,
                                        logic [3:0] s);
    for (int b = 0; b < 4; b++)
      if (s[b]) o[8*b+:8] = n[8*b+:8];
    return o;
  endfunction : merge
  assign adr = {wb_adr_i[ADDR_W-1:2], 2'h0};
  assign wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
  assign mode = cfg[`CFG_PRES_SEL_LSB+:2];
  assign inv_pd = {NPORTS{cfg[`CFG_INV_PRESENCE]}};
  // Outputs lag the stored state by one edge, so wait one quiet cycle
  assign settled = cfg == cfg_d && ctl == ctl_d && !hot_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) cfg <= `CFG_RESET;
    else if (wr && adr == ADDR_W'(`OFF_CONFIG))
      cfg <= merge(cfg, wb_dat_i, wb_sel_i);
  end
  always_ff @(posedge clk_i) begin
    if (rst_i || hot_rst_i) ctl <= 32'h0000_0000;
    else if (wr && adr == ADDR_W'(`OFF_SLOT_CONTROL))
      ctl <= merge(ctl, wb_dat_i, wb_sel_i) & 32'h00FF_FF00;
  end
  always_ff @(posedge clk_i) begin
    cfg_d <= cfg;
    ctl_d <= ctl;
    // Either reset forces the port outputs, so skip the edge after it
    hot_q <= hot_rst_i || rst_i;
  end
  default clocking cb @(posedge clk_i); endclocking
  property p_rst_state;
    disable iff (rst_i) $fell(rst_i) |-> slot_reset_out_o == '1 &&
      presence_report_o == '0 && !wb_ack_o;
  endproperty
  a_rst_state: assert property (p_rst_state)
    else $error("reset state wrong after reset");
  property p_ack_latency;
    disable iff (rst_i) wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack_latency: assert property (p_ack_latency)
    else $error("bus ack late");
  property p_pres_both;
    disable iff (rst_i) settled && mode == 2'h0 |-> presence_report_o ==
      ($past(receiver_detect_i) | ($past(presence_detect_in_i) ^ inv_pd));
  endproperty
  a_pres_both: assert property (p_pres_both)
    else $error("presence in mode 0 wrong");
  property p_pres_signal;
    disable iff (rst_i) settled && mode == 2'h1 |->
      presence_report_o == ($past(presence_detect_in_i) ^ inv_pd);
  endproperty
  a_pres_signal: assert property (p_pres_signal)
    else $error("presence in mode 1 wrong");
  property p_pres_fixed;
    disable iff (rst_i) settled && mode[1] |->
      presence_report_o == (mode[0] ? '0 : '1);
  endproperty
  a_pres_fixed: assert property (p_pres_fixed)
    else $error("fixed presence wrong");
  property p_attn;
    disable iff (rst_i) settled |-> attention_indicator_out_o ==
      (ctl[8+:NPORTS] ^ {NPORTS{cfg[`CFG_INV_ATTN]}});
  endproperty
  a_attn: assert property (p_attn)
    else $error("attention output polarity wrong");
  property p_pind;
    disable iff (rst_i) settled |-> power_indicator_out_o ==
      (ctl[16+:NPORTS] ^ {NPORTS{cfg[`CFG_INV_PIND]}});
  endproperty
  a_pind: assert property (p_pind)
    else $error("power indicator polarity wrong");
  property p_cfg_read;
    disable iff (rst_i) wb_ack_o && !wb_we_i &&
      adr == ADDR_W'(`OFF_CONFIG) |-> wb_dat_o == cfg;
  endproperty
  a_cfg_read: assert property (p_cfg_read)
    else $error("config read value wrong");
endmodule : hotplug_slot_signal_config_assertions

/* tb/slot_model.sv */
// Behavioural slot hardware: power controller and latch sensor.
// Assumes pins synchronous to clk_i; polarity bits come from the bench.
`timescale 1ns/1ps

module slot_model #(
  parameter int GOOD_DELAY = 20
) (
  input  wire logic clk_i,
  input  wire logic power_pin_i,
  input  wire logic inv_power_i,
  input  wire logic inv_good_i,
  input  wire logic latch_open_i,
  input  wire logic inv_latch_i,
  output logic      good_pin_o,
  output logic      latch_pin_o
);
  int   on_count = 0;
  logic powered;
  assign powered = power_pin_i ^ inv_power_i;
  always_ff @(posedge clk_i) begin
    if (powered !== 1'b1) on_count <= 0;
    else if (on_count < GOOD_DELAY) on_count <= on_count + 1;
  end
  // Good drops at once on power loss; no hold-up is modelled
  assign good_pin_o = (powered === 1'b1 && on_count >= GOOD_DELAY)
                      ^ inv_good_i;
  assign latch_pin_o = latch_open_i ^ inv_latch_i;
endmodule : slot_model

/* tb/hotplug_slot_signal_config_test.sv */
// Self-checking bench for the hot-plug slot signal configuration block.
// Assumes two slot models and short 4-cycle delay steps.
`timescale 1ns/1ps
`include "hotplug_map.svh"

module hotplug_slot_signal_config_test;
  localparam int STEP = 4;
  logic        clk_i = 0, rst_i = 1, hot_rst_i = 0;
  logic        cyc = 0, stb = 0, we = 0, ack;
  logic [11:0] adr = 0;
  logic [3:0]  sel = 0;
  logic [31:0] dat_w = 0, dat_r, cfg_now = 32'h1414_0800;
  logic [1:0]  pd = 0, rx = 0, latch_open = 0;
  wire  [1:0]  latch_pin, pg;
  logic [1:0]  attn, pind, pwr, ilock, srst, pres;
  int          bad_count = 0, n_checks = 0;
  typedef struct {
    logic [31:0] cfg, ctl;
    logic [1:0]  pd, rx, pres, attn, pind;
  } row_type;
  row_type rows [6] = '{
    '{32'h0000_0000, 32'h0002_0100, 2'h1, 2'h2, 2'h3, 2'h1, 2'h2},
    '{32'h0000_0200, 32'h0000_0000, 2'h1, 2'h2, 2'h1, 2'h0, 2'h0},
    '{32'h0000_0202, 32'h0000_0000, 2'h1, 2'h0, 2'h2, 2'h0, 2'h0},
    '{32'h0000_0400, 32'h0000_0000, 2'h0, 2'h0, 2'h3, 2'h0, 2'h0},
    '{32'h0000_0600, 32'h0000_0000, 2'h3, 2'h3, 2'h0, 2'h0, 2'h0},
    '{32'h0000_00F0, 32'h0001_0100, 2'h0, 2'h0, 2'h0, 2'h2, 2'h2}};
  always #12.5 clk_i = ~clk_i;
  hotplug_slot_signal_config #(.STEP_CYCLES(STEP)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .hot_rst_i(hot_rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack),
    .latch_sensor_in_i(latch_pin), .presence_detect_in_i(pd),
    .slot_power_good_in_i(pg), .receiver_detect_i(rx),
    .attention_indicator_out_o(attn), .power_indicator_out_o(pind),
    .slot_power_enable_out_o(pwr), .interlock_out_o(ilock),
    .slot_reset_out_o(srst), .presence_report_o(pres));
  for (genvar p = 0; p < 2; p++) begin : g_slot
    slot_model u_slot (.clk_i(clk_i), .power_pin_i(pwr[p]),
      .inv_power_i(cfg_now[6]), .inv_good_i(cfg_now[8]),
      .latch_open_i(latch_open[p]), .inv_latch_i(cfg_now[3]),
      .good_pin_o(pg[p]), .latch_pin_o(latch_pin[p]));
  end
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : results
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic xfer(logic w, logic [11:0] a, logic [31:0] d,
                      output logic [31:0] q);
    @(posedge clk_i);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    dat_w <= d;
    sel <= 4'hF;
    do @(posedge clk_i); while (ack !== 1'b1);
    q = dat_r;
    cyc <= 0;
    stb <= 0;
  endtask : xfer
  task automatic wr(logic [11:0] a, logic [31:0] d);
    logic [31:0] q;
    xfer(1, a, d, q);
  endtask : wr
  // Only codes 0 and 1 go into the reset-mode field
  task automatic set_cfg(logic [31:0] d);
    cfg_now <= d;
    wr(`OFF_CONFIG, d);
  endtask : set_cfg
  task automatic wait_for(int kind, int p, logic v, output int n);
    n = 0;
    while ((kind == 0 ? pwr[p] : kind == 1 ? srst[p] : ilock[p]) !== v
           && n < 500) begin
      @(negedge clk_i);
      n++;
    end
    // A wait that runs out must not pass as a slow but good sequence
    check("wait limit", 32'(n >= 500), 0);
  endtask : wait_for
  initial begin
    #(25ns * 20000);
    bad_count++;
    results();
  end
  initial begin
    int n;
    logic [31:0] q;
    repeat (12) @(posedge clk_i);
    rst_i <= 0;
    xfer(0, `OFF_CONFIG, 0, q);
    check("config reset", q, 32'h1414_0800);
    xfer(0, 12'h7F0, 0, q);
    check("unmapped read", q, 0);
    foreach (rows[i]) begin
      pd <= rows[i].pd;
      rx <= rows[i].rx;
      set_cfg(rows[i].cfg);
      wr(`OFF_SLOT_CONTROL, rows[i].ctl);
      repeat (3) @(negedge clk_i);
      check("presence", 32'(pres), 32'(rows[i].pres));
      check("attention", 32'(attn), 32'(rows[i].attn));
      check("power ind", 32'(pind), 32'(rows[i].pind));
      check("power en", 32'(pwr), 32'({2{rows[i].cfg[6]}}));
      check("interlock", 32'(ilock), 32'({2{rows[i].cfg[7]}}));
    end
    $display("table done");
    set_cfg(32'h0302_0000);
    wr(`OFF_SLOT_CONTROL, 1);
    wait_for(0, 0, 1, n);
    wait_for(1, 0, 0, n);
    check("up delay", 32'(n >= 2 * STEP && n <= 2 * STEP + 3), 1);
    wr(`OFF_SLOT_CONTROL, 0);
    wait_for(1, 0, 1, n);
    check("power held", 32'(pwr[0]), 1);
    wait_for(0, 0, 0, n);
    check("down delay", 32'(n >= 3 * STEP && n <= 3 * STEP + 3), 1);
    set_cfg(32'h0001_4100);
    wr(`OFF_SLOT_CONTROL, 1);
    wait_for(0, 0, 1, n);
    wait_for(1, 0, 0, n);
    check("good delay", 32'(n >= 20 + STEP && n <= 26 + STEP), 1);
    wr(`OFF_SLOT_CONTROL, 0);
    wait_for(0, 0, 0, n);
    check("no down delay", 32'(n <= 4), 1);
    $display("sequence done");
    wr(`OFF_SLOT_CAP, 2);
    set_cfg(32'h0100_1808);
    wr(`OFF_SLOT_CONTROL, 2);
    wait_for(1, 1, 0, n);
    latch_open <= 2'h2;
    repeat (30) @(negedge clk_i);
    check("lock mode power", 32'(pwr[1]), 1);
    xfer(0, `OFF_SLOT_STATUS, 0, q);
    check("lock status", q, 32'h0000_1C20);
    set_cfg(32'h0100_0808);
    wait_for(0, 1, 0, n);
    check("auto power off", 32'(n < 30), 1);
    latch_open <= 2'h0;
    wr(`OFF_SLOT_CONTROL, 0);
    $display("latch done");
    set_cfg(32'h0000_0000);
    wr(`OFF_SLOT_CONTROL, 32'h0100_0000);
    wait_for(2, 0, 1, n);
    wait_for(2, 0, 0, n);
    check("pulse", 32'(n >= 10 * STEP && n <= 15 * STEP), 1);
    set_cfg(32'h0000_2000);
    for (int k = 0; k < 2; k++) begin
      wr(`OFF_SLOT_CONTROL, 32'h0100_0000);
      repeat (3) @(negedge clk_i);
      check("toggle", 32'(ilock[0]), 32'(k == 0));
    end
    $display("interlock done");
    set_cfg(32'h0505_0000);
    hot_rst_i <= 1;
    repeat (3) @(posedge clk_i);
    hot_rst_i <= 0;
    xfer(0, `OFF_CONFIG, 0, q);
    check("sticky config", q, 32'h0505_0000);
    xfer(0, `OFF_SLOT_CAP, 0, q);
    check("sticky cap", q, 2);
    rst_i <= 1;
    cfg_now <= 32'h1414_0800;
    repeat (3) @(posedge clk_i);
    rst_i <= 0;
    xfer(0, `OFF_CONFIG, 0, q);
    check("full reset", q, 32'h1414_0800);
    $display("reset done");
    results();
  end
endmodule : hotplug_slot_signal_config_test

bind hotplug_slot_signal_config hotplug_slot_signal_config_assertions #(
  .NPORTS(NPORTS), .ADDR_W(ADDR_W)) u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .hot_rst_i(hot_rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .presence_detect_in_i(presence_detect_in_i),
  .receiver_detect_i(receiver_detect_i),
  .attention_indicator_out_o(attention_indicator_out_o),
  .power_indicator_out_o(power_indicator_out_o),
  .slot_reset_out_o(slot_reset_out_o),
  .presence_report_o(presence_report_o));
